// File: otfs_pkg.sv
// package for the output terminal function selector
package otfs_pkg;
    localparam logic [11:0] OFF_DIGITAL_SEL  = 12'h000;
    localparam logic [11:0] OFF_RELAY_SEL    = 12'h004;
    localparam logic [11:0] OFF_RSVD_A       = 12'h008;
    localparam logic [11:0] OFF_RSVD_B       = 12'h00C;
    localparam logic [11:0] OFF_SWITCH_SEL   = 12'h010;
    localparam logic [11:0] OFF_STATUS       = 12'h014;
    localparam logic [11:0] OFF_COND         = 12'h018;

    localparam logic [15:0] RST_DIGITAL_SEL  = 16'h0001;
    localparam logic [15:0] RST_RELAY_SEL    = 16'h0002;
    localparam logic [15:0] RST_SWITCH_SEL   = 16'h0000;

    localparam int          CODE_W           = 16;
    localparam int          NUM_TERM         = 3;
    localparam int          TERM_DIGITAL     = 0;
    localparam int          TERM_RELAY       = 1;
    localparam int          TERM_SWITCH      = 2;

    localparam logic [15:0] CODE_NONE        = 16'h0000;
    localparam logic [15:0] CODE_RUNNING     = 16'h0001;
    localparam logic [15:0] CODE_FAULT_STOP  = 16'h0002;
    localparam logic [15:0] CODE_FREQ_LEVEL  = 16'h0003;
    localparam logic [15:0] CODE_FREQ_ARRIVE = 16'h0004;
    localparam logic [15:0] CODE_ZERO_RUN    = 16'h0005;
    localparam logic [15:0] CODE_MOTOR_OL    = 16'h0006;
    localparam logic [15:0] CODE_DRIVE_OL    = 16'h0007;
    localparam logic [15:0] CODE_SET_COUNT   = 16'h0008;
    localparam logic [15:0] CODE_DESIG_COUNT = 16'h0009;
    localparam logic [15:0] CODE_LENGTH      = 16'h000A;
    localparam logic [15:0] CODE_SEQ_CYCLE   = 16'h000B;
    localparam logic [15:0] CODE_RUN_TIME    = 16'h000C;
    localparam logic [15:0] CODE_FREQ_LIMIT  = 16'h000D;
    localparam logic [15:0] CODE_TORQUE_LIM  = 16'h000E;
    localparam logic [15:0] CODE_READY       = 16'h000F;
    localparam logic [15:0] CODE_ANALOG_CMP  = 16'h0010;
    localparam logic [15:0] CODE_UPPER_LIM   = 16'h0011;
    localparam logic [15:0] CODE_LOWER_LIM   = 16'h0012;

    localparam int          CLK_HZ           = 20000000;
    localparam int          PULSE_MS         = 250;
    localparam int          PULSE_CYCLES     = CLK_HZ / 1000 * PULSE_MS;
    localparam int          PRE_ALARM_S      = 10;
    localparam int          PULSE_CNT_W      = 23;

    // drive status inputs gathered together
    typedef struct packed {
        logic       running;
        logic       fault_stop;
        logic       freq_level_detect_one;
        logic       freq_arrive;
        logic       out_freq_zero;
        logic       motor_ol_prealarm;
        logic       drive_ol_prealarm;
        logic       set_count_reached;
        logic       desig_count_reached;
        logic       length_reached;
        logic       seq_cycle_done;
        logic       run_time_reached;
        logic       setpoint_beyond_limit;
        logic       at_upper_limit;
        logic       at_lower_limit;
        logic       speed_mode;
        logic       torque_at_limit;
        logic       stall_protect;
        logic       supplies_stable;
        logic       able_to_run;
        logic [15:0] analog_in_one;
        logic [15:0] analog_in_two;
    } otfs_status_t;

    typedef struct packed {
        logic multiplex_switch_out;
        logic relay_contacts;
        logic digital_out_one;
    } otfs_terms_t;
endpackage

// File: otfs_pulse.sv
// stretches a one-cycle event into a fixed-width pulse
`timescale 1ns/10ps
`default_nettype none
module otfs_pulse
    import otfs_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic trig,
    output logic      pulse
);
    logic [PULSE_CNT_W-1:0] cnt_reg;

    // reload on each event, count down to zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (trig) begin
            cnt_reg <= PULSE_CNT_W'(PULSE_CYCLES);
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign pulse = (cnt_reg != '0);
endmodule
`default_nettype wire

// File: otfs_top.sv
// output terminal function selector with apb registers
`timescale 1ns/10ps
`default_nettype none
// What this block does
// (R1) digital output code register, reset value 1
// (R2) relay output code register, reset value 2
// (R3) switch-mode multiplexed terminal code register, reset value 0
// (R4) code 0 keeps terminal off
// (R5) code 1 on while running, even at zero frequency
// (R6) code 2 on for a stopping fault
// (R7) codes 3 and 4 follow level-detect and arrival flags
// (R8) code 5 on when running at zero frequency, off stopped
// (R9) code 6 follows motor overload pre-alarm flag
// (R10) code 7 follows drive overload pre-alarm, ten seconds ahead
// (R11) code 8 on at set count reached
// (R12) code 9 on at designated count reached
// (R13) code 10 on when length exceeds setting
// (R14) code 11 gives one 250 ms pulse per sequencer cycle
// (R15) code 12 on when running time exceeds threshold
// (R16) code 13 on when setpoint beyond limit and output at limit
// (R17) code 14 on in speed mode at torque limit with stall protection
// (R18) code 15 on when supplies stable, no fault, able to run
// (R19) code 16 on while analog one strictly above analog two
// (R20) code 17 on at upper limit frequency
// (R21) code 18 on at lower limit while running, off stopped
// (R22) undefined codes leave terminal off
module otfs_top
    import otfs_pkg::*;
(
    input  wire logic          sys_clk,
    input  wire logic          rst,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire otfs_status_t  status,
    output otfs_terms_t        terms
);
    typedef enum logic [1:0] {
        OTFS_IDLE   = 2'b00,
        OTFS_SETUP  = 2'b01,
        OTFS_ACCESS = 2'b11
    } otfs_bus_state_t;

    otfs_bus_state_t      bus_state_reg;
    otfs_bus_state_t      bus_state_next;
    logic [CODE_W-1:0]    digital_sel_reg;
    logic [CODE_W-1:0]    relay_sel_reg;
    logic [CODE_W-1:0]    switch_sel_reg;
    logic [31:0]          prdata_reg;
    logic                 pslverr_reg;
    logic                 seq_done_d_reg;
    logic                 seq_pulse;
    logic                 seq_trig;
    logic [NUM_TERM-1:0]  term_reg;
    logic [NUM_TERM-1:0]  term_next;
    logic                 wr_en;
    logic                 rd_en;

    // condition chosen by one function code
    function automatic logic select_cond(input logic [CODE_W-1:0] code,
                                         input otfs_status_t st,
                                         input logic pulse_on);
        logic c;
        c = 1'b0;
        case (code)
            CODE_NONE:        c = 1'b0;                                  // [R4]
            CODE_RUNNING:     c = st.running;                            // [R5]
            CODE_FAULT_STOP:  c = st.fault_stop;                         // [R6]
            CODE_FREQ_LEVEL:  c = st.freq_level_detect_one;              // [R7]
            CODE_FREQ_ARRIVE: c = st.freq_arrive;                        // [R7]
            CODE_ZERO_RUN:    c = st.running & st.out_freq_zero;         // [R8]
            CODE_MOTOR_OL:    c = st.motor_ol_prealarm;                  // [R9]
            CODE_DRIVE_OL:    c = st.drive_ol_prealarm;                  // [R10]
            CODE_SET_COUNT:   c = st.set_count_reached;                  // [R11]
            CODE_DESIG_COUNT: c = st.desig_count_reached;                // [R12]
            CODE_LENGTH:      c = st.length_reached;                     // [R13]
            CODE_SEQ_CYCLE:   c = pulse_on;                              // [R14]
            CODE_RUN_TIME:    c = st.run_time_reached;                   // [R15]
            CODE_FREQ_LIMIT:  c = st.setpoint_beyond_limit
                                  & (st.at_upper_limit | st.at_lower_limit); // [R16]
            CODE_TORQUE_LIM:  c = st.speed_mode & st.torque_at_limit
                                  & st.stall_protect;                    // [R17]
            CODE_READY:       c = st.supplies_stable & ~st.fault_stop
                                  & st.able_to_run;                      // [R18]
            CODE_ANALOG_CMP:  c = st.analog_in_one > st.analog_in_two;   // [R19]
            CODE_UPPER_LIM:   c = st.at_upper_limit;                     // [R20]
            CODE_LOWER_LIM:   c = st.running & st.at_lower_limit;        // [R21]
            default:          c = 1'b0;                                  // [R22]
        endcase
        return c;
    endfunction

    // apb slave sequencing
    always_comb begin
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            OTFS_IDLE: begin
                if (psel && !penable) begin
                    bus_state_next = OTFS_SETUP;
                end
            end
            OTFS_SETUP: begin
                bus_state_next = OTFS_ACCESS;
            end
            OTFS_ACCESS: begin
                if (psel && !penable) begin
                    bus_state_next = OTFS_SETUP;
                end else begin
                    bus_state_next = OTFS_IDLE;
                end
            end
            default: bus_state_next = OTFS_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            bus_state_reg <= OTFS_IDLE;
        end else begin
            bus_state_reg <= bus_state_next;
        end
    end

    assign pready = 1'b1;
    assign wr_en  = psel && penable && pwrite && (bus_state_reg == OTFS_SETUP);
    assign rd_en  = psel && !penable && !pwrite;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg;

    // function code registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            digital_sel_reg <= RST_DIGITAL_SEL;                          // [R1]
            relay_sel_reg   <= RST_RELAY_SEL;                            // [R2]
            switch_sel_reg  <= RST_SWITCH_SEL;                           // [R3]
        end else if (wr_en) begin
            if (paddr == OFF_DIGITAL_SEL) begin
                if (pstrb[0]) digital_sel_reg[7:0]  <= pwdata[7:0];
                if (pstrb[1]) digital_sel_reg[15:8] <= pwdata[15:8];
            end else if (paddr == OFF_RELAY_SEL) begin
                if (pstrb[0]) relay_sel_reg[7:0]  <= pwdata[7:0];
                if (pstrb[1]) relay_sel_reg[15:8] <= pwdata[15:8];
            end else if (paddr == OFF_SWITCH_SEL) begin
                if (pstrb[0]) switch_sel_reg[7:0]  <= pwdata[7:0];
                if (pstrb[1]) switch_sel_reg[15:8] <= pwdata[15:8];
            end
        end
    end

    // read data captured in the setup cycle, error on unmapped address
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (psel && !penable) begin
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            if (paddr == OFF_DIGITAL_SEL) begin
                if (rd_en) prdata_reg <= {16'h0000, digital_sel_reg};
            end else if (paddr == OFF_RELAY_SEL) begin
                if (rd_en) prdata_reg <= {16'h0000, relay_sel_reg};
            end else if (paddr == OFF_RSVD_A || paddr == OFF_RSVD_B) begin
                prdata_reg <= 32'h0000_0000;
            end else if (paddr == OFF_SWITCH_SEL) begin
                if (rd_en) prdata_reg <= {16'h0000, switch_sel_reg};
            end else if (paddr == OFF_STATUS) begin
                if (rd_en) prdata_reg <= {29'h0, term_reg};
            end else if (paddr == OFF_COND) begin
                if (rd_en) begin
                    prdata_reg <= {12'h000, status.running, status.fault_stop,
                                   status.freq_level_detect_one, status.freq_arrive,
                                   status.out_freq_zero, status.motor_ol_prealarm,
                                   status.drive_ol_prealarm, status.set_count_reached,
                                   status.desig_count_reached, status.length_reached,
                                   seq_pulse, status.run_time_reached,
                                   status.setpoint_beyond_limit, status.at_upper_limit,
                                   status.at_lower_limit, status.speed_mode,
                                   status.torque_at_limit, status.stall_protect,
                                   status.supplies_stable, status.able_to_run};
                end
            end else begin
                pslverr_reg <= 1'b1;
            end
        end else begin
            pslverr_reg <= 1'b0;
        end
    end

    // rising edge of sequencer cycle completion
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            seq_done_d_reg <= 1'b0;
        end else begin
            seq_done_d_reg <= status.seq_cycle_done;
        end
    end

    assign seq_trig = status.seq_cycle_done & ~seq_done_d_reg;          // [R14]

    otfs_pulse u_seq_pulse (
        .sys_clk (sys_clk),
        .rst     (rst),
        .trig    (seq_trig),
        .pulse   (seq_pulse)
    );

    always_comb begin
        term_next[TERM_DIGITAL] = select_cond(digital_sel_reg, status, seq_pulse);
        term_next[TERM_RELAY]   = select_cond(relay_sel_reg, status, seq_pulse);
        term_next[TERM_SWITCH]  = select_cond(switch_sel_reg, status, seq_pulse);
    end

    // terminal outputs registered
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            term_reg <= '0;
        end else begin
            term_reg <= term_next;
        end
    end

    assign terms.digital_out_one      = term_reg[TERM_DIGITAL];
    assign terms.relay_contacts       = term_reg[TERM_RELAY];
    assign terms.multiplex_switch_out = term_reg[TERM_SWITCH];

    property p_code_zero_off;
        @(posedge sys_clk) disable iff (rst)
        (digital_sel_reg == CODE_NONE) |=> !terms.digital_out_one;
    endproperty
    a_code_zero_off: assert property (p_code_zero_off) // [R4]
        else $error("digital out on with code zero");

    property p_running;
        @(posedge sys_clk) disable iff (rst)
        (relay_sel_reg == CODE_RUNNING) |=> (terms.relay_contacts == $past(status.running));
    endproperty
    a_running: assert property (p_running) // [R5]
        else $error("relay not tracking running");

    property p_zero_run;
        @(posedge sys_clk) disable iff (rst)
        (switch_sel_reg == CODE_ZERO_RUN && !status.running) |=> !terms.multiplex_switch_out;
    endproperty
    a_zero_run: assert property (p_zero_run) // [R8]
        else $error("zero speed output on while stopped");

    property p_lower_stop;
        @(posedge sys_clk) disable iff (rst)
        (digital_sel_reg == CODE_LOWER_LIM && !status.running) |=> !terms.digital_out_one;
    endproperty
    a_lower_stop: assert property (p_lower_stop) // [R21]
        else $error("lower limit output on while stopped");

    property p_analog;
        @(posedge sys_clk) disable iff (rst)
        (digital_sel_reg == CODE_ANALOG_CMP)
            |=> (terms.digital_out_one == $past(status.analog_in_one > status.analog_in_two));
    endproperty
    a_analog: assert property (p_analog) // [R19]
        else $error("analog compare output wrong");

    property p_undefined;
        @(posedge sys_clk) disable iff (rst)
        (relay_sel_reg > CODE_LOWER_LIM) |=> !terms.relay_contacts;
    endproperty
    a_undefined: assert property (p_undefined) // [R22]
        else $error("undefined code drives relay");

    property p_pulse_start;
        @(posedge sys_clk) disable iff (rst)
        seq_trig |=> seq_pulse [*8];
    endproperty
    a_pulse_start: assert property (p_pulse_start) // [R14]
        else $error("sequencer pulse not started");

    property p_ready;
        @(posedge sys_clk) disable iff (rst)
        (switch_sel_reg == CODE_READY && status.fault_stop) |=> !terms.multiplex_switch_out;
    endproperty
    a_ready: assert property (p_ready) // [R18]
        else $error("ready on with fault");

    property p_fault;
        @(posedge sys_clk) disable iff (rst)
        (relay_sel_reg == CODE_FAULT_STOP) |=> (terms.relay_contacts == $past(status.fault_stop));
    endproperty
    a_fault: assert property (p_fault) // [R6]
        else $error("relay not tracking fault");

    property p_freq_level;
        @(posedge sys_clk) disable iff (rst)
        (digital_sel_reg == CODE_FREQ_LEVEL)
            |=> (terms.digital_out_one == $past(status.freq_level_detect_one));
    endproperty
    a_freq_level: assert property (p_freq_level) // [R7]
        else $error("digital out not tracking level detect");

    property p_motor_ol;
        @(posedge sys_clk) disable iff (rst)
        (relay_sel_reg == CODE_MOTOR_OL)
            |=> (terms.relay_contacts == $past(status.motor_ol_prealarm));
    endproperty
    a_motor_ol: assert property (p_motor_ol) // [R9]
        else $error("relay not tracking motor pre-alarm");

    property p_drive_ol;
        @(posedge sys_clk) disable iff (rst)
        (switch_sel_reg == CODE_DRIVE_OL)
            |=> (terms.multiplex_switch_out == $past(status.drive_ol_prealarm));
    endproperty
    a_drive_ol: assert property (p_drive_ol) // [R10]
        else $error("switch out not tracking drive pre-alarm");

    property p_set_count;
        @(posedge sys_clk) disable iff (rst)
        (digital_sel_reg == CODE_SET_COUNT)
            |=> (terms.digital_out_one == $past(status.set_count_reached));
    endproperty
    a_set_count: assert property (p_set_count) // [R11]
        else $error("digital out not tracking set count");

    property p_length;
        @(posedge sys_clk) disable iff (rst)
        (relay_sel_reg == CODE_LENGTH)
            |=> (terms.relay_contacts == $past(status.length_reached));
    endproperty
    a_length: assert property (p_length) // [R13]
        else $error("relay not tracking length reached");

    property p_freq_limit;
        @(posedge sys_clk) disable iff (rst)
        (relay_sel_reg == CODE_FREQ_LIMIT && !status.setpoint_beyond_limit)
            |=> !terms.relay_contacts;
    endproperty
    a_freq_limit: assert property (p_freq_limit) // [R16]
        else $error("frequency limit output on with setpoint inside");

    property p_upper;
        @(posedge sys_clk) disable iff (rst)
        (switch_sel_reg == CODE_UPPER_LIM)
            |=> (terms.multiplex_switch_out == $past(status.at_upper_limit));
    endproperty
    a_upper: assert property (p_upper) // [R20]
        else $error("switch out not tracking upper limit");

    c_write: cover property (@(posedge sys_clk) disable iff (rst) wr_en);
    c_pulse: cover property (@(posedge sys_clk) disable iff (rst) seq_trig);
    c_err:   cover property (@(posedge sys_clk) disable iff (rst) pslverr_reg);
    c_all:   cover property (@(posedge sys_clk) disable iff (rst) (&term_reg));
    c_read:  cover property (@(posedge sys_clk) disable iff (rst) rd_en);
endmodule
`default_nettype wire

// File: otfs_equip_model.sv
// model of equipment wired to the output terminals
`timescale 1ns/10ps
`default_nettype none
module otfs_equip_model
    import otfs_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire otfs_terms_t terms,
    output logic [31:0]      on_run,
    output logic [2:0]       seen_on
);
    // cycles the digital terminal has been on without a break
    always_ff @(posedge sys_clk) begin
        if (rst || !terms.digital_out_one) begin
            on_run <= 32'h0;
        end else begin
            on_run <= on_run + 32'h1;
        end
    end

    // sticky record of each terminal seen on
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            seen_on <= 3'h0;
        end else begin
            seen_on <= seen_on | terms;
        end
    end
endmodule
`default_nettype wire

// File: otfs_top_tb.sv
// self-checking bench for the output terminal function selector
`timescale 1ns/10ps
`default_nettype none
module otfs_top_tb
    import otfs_pkg::*;
;
    logic         sys_clk = 1'b0;
    logic         rst     = 1'b1;
    logic         psel    = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite  = 1'b0;
    logic [11:0]  paddr   = 12'h000;
    logic [31:0]  pwdata  = 32'h0;
    logic [3:0]   pstrb   = 4'hF;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    otfs_status_t status  = '0;
    otfs_terms_t  terms;
    logic [31:0]  on_run;
    logic [2:0]   seen_on;
    logic [31:0]  rd;
    logic         er;
    logic [15:0]  code;
    logic         exp;
    int           errors = 0;
    int           samples_checked = 0;

    always #25 sys_clk = ~sys_clk;

    otfs_top otfs_top_i (
        .sys_clk (sys_clk), .rst (rst), .psel (psel), .penable (penable),
        .pwrite (pwrite), .paddr (paddr), .pwdata (pwdata), .pstrb (pstrb),
        .prdata (prdata), .pready (pready), .pslverr (pslverr),
        .status (status), .terms (terms)
    );

    otfs_equip_model otfs_equip_model_i (
        .sys_clk (sys_clk), .rst (rst), .terms (terms),
        .on_run (on_run), .seen_on (seen_on)
    );

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    // apb transfer, holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            errors++;
            $display("MISMATCH pready expected 1 seen %b", pready);
            print_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic put(input otfs_status_t s);
        @(posedge sys_clk);
        status <= s;
        repeat (3) @(posedge sys_clk);
    endtask

    // status that makes a code's condition true or false
    function automatic otfs_status_t mk(input logic [15:0] c, input logic on);
        otfs_status_t s;
        s = '0;
        case (c)
            16'h0001: begin s.running = on; s.out_freq_zero = 1'b1; end
            16'h0002: s.fault_stop = on;
            16'h0003: s.freq_level_detect_one = on;
            16'h0004: s.freq_arrive = on;
            16'h0005: begin s.running = on; s.out_freq_zero = 1'b1; end
            16'h0006: s.motor_ol_prealarm = on;
            16'h0007: s.drive_ol_prealarm = on;
            16'h0008: s.set_count_reached = on;
            16'h0009: s.desig_count_reached = on;
            16'h000A: s.length_reached = on;
            16'h000B: s = '0;
            16'h000C: s.run_time_reached = on;
            16'h000D: begin s.setpoint_beyond_limit = on; s.at_upper_limit = 1'b1; end
            16'h000E: begin
                s.speed_mode = 1'b1;
                s.torque_at_limit = 1'b1;
                s.stall_protect = on;
            end
            16'h000F: begin
                s.supplies_stable = 1'b1;
                s.able_to_run = 1'b1;
                s.fault_stop = !on;
            end
            16'h0010: begin
                s.analog_in_one = on ? 16'h8001 : 16'h8000;
                s.analog_in_two = 16'h8000;
            end
            16'h0011: s.at_upper_limit = on;
            16'h0012: begin s.running = on; s.at_lower_limit = 1'b1; end
            default: begin
                if (on) begin
                    s = '1;
                    s.seq_cycle_done = 1'b0;
                end
            end
        endcase
        return s;
    endfunction

    initial begin
        otfs_status_t s;
        repeat (5) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, OFF_DIGITAL_SEL, 32'h0);
        chk("digital_sel", 32'h1, rd);
        apb(1'b0, OFF_RELAY_SEL, 32'h0);
        chk("relay_sel", 32'h2, rd);
        apb(1'b0, OFF_SWITCH_SEL, 32'h0);
        chk("switch_sel", 32'h0, rd);
        apb(1'b0, OFF_RSVD_A, 32'h0);
        chk("rsvd_err", 32'h0, {31'h0, er});
        apb(1'b0, 12'h020, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, er});
        s = '0;
        s.running = 1'b1;
        put(s);
        chk("terms_running", 32'h1, {29'h0, terms});
        s = '0;
        s.fault_stop = 1'b1;
        put(s);
        chk("terms_fault", 32'h2, {29'h0, terms});
        apb(1'b0, OFF_STATUS, 32'h0);
        chk("terms_reg", 32'h2, rd);
        apb(1'b0, OFF_COND, 32'h0);
        chk("cond_reg", 32'h0004_0000, rd);
        $display("test defaults done");

        for (int i = 0; i < 22; i++) begin
            code = (i < 20) ? 16'(i) : ((i == 20) ? 16'h00FF : 16'hFFFF);
            exp = (code >= 16'h0001) && (code <= 16'h0012);
            apb(1'b1, OFF_DIGITAL_SEL, {16'h0, code});
            apb(1'b1, OFF_RELAY_SEL, {16'h0, code});
            apb(1'b1, OFF_SWITCH_SEL, {16'h0, code});
            apb(1'b0, OFF_RELAY_SEL, 32'h0);
            chk("relay_sel", {16'h0, code}, rd);
            put(mk(code, 1'b0));
            chk("terms_off", 32'h0, {29'h0, terms});
            if (code == 16'h000B) begin
                s = '0;
                s.seq_cycle_done = 1'b1;
                @(posedge sys_clk);
                status <= s;
                @(posedge sys_clk);
                status <= '0;
                repeat (20) @(posedge sys_clk);
                chk("pulse_terms", 32'h7, {29'h0, terms});
                chk("pulse_held", 32'h1, {31'h0, on_run >= 32'd15});
            end else begin
                put(mk(code, 1'b1));
                chk("terms_on", {29'h0, {3{exp}}}, {29'h0, terms});
            end
            $display("test code %0d done", code);
        end
        chk("seen_on", 32'h7, {29'h0, seen_on});
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, OFF_DIGITAL_SEL, 32'h0);
        chk("digital_sel_rst", 32'h1, rd);
        apb(1'b0, OFF_RELAY_SEL, 32'h0);
        chk("relay_sel_rst", 32'h2, rd);
        apb(1'b0, OFF_SWITCH_SEL, 32'h0);
        chk("switch_sel_rst", 32'h0, rd);
        chk("terms_rst", 32'h3, {29'h0, terms});
        apb(1'b0, OFF_COND, 32'h0);
        chk("cond_rst", 32'h000F_FDFF, rd);
        $display("test mid-run reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
